// >>> rtl/core_alu_pkg.sv
// constants, opcode fields and phase states of the core alu datapath
package core_alu_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int INSTR_W = 14;
   localparam int BIT_IDX_W = 3;
   // field positions inside the instruction word
   localparam int DEST_POS = 7;
   localparam int BIT_IDX_LSB = 7;
   localparam int ADDR_LSB = 0;
   localparam int LIT_LSB = 0;
   // opcode fields, compared against the top bits of the word
   localparam logic [5:0] OPC_ADD_FILE = 6'h07;
   localparam logic [5:0] OPC_AND_FILE = 6'h05;
   localparam logic [6:0] OPC_CLEAR_FILE = 7'h03;
   localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
   localparam logic [3:0] OPC_BIT_SET = 4'h5;
   localparam logic [3:0] OPC_SKIP_CLEAR = 4'h6;
   localparam logic [3:0] OPC_SKIP_SET = 4'h7;
   localparam logic [4:0] OPC_ADD_LIT = 5'h1F;
   localparam logic [5:0] OPC_AND_LIT = 6'h39;
   // no-operation word, also what a discarded slot executes
   localparam logic [13:0] INSTR_NOP = 14'h0000;
   // reset values and the one-bit mask seed
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] DATA_ZERO = 8'h00;
   localparam logic [7:0] BIT_ONE = 8'h01;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic FLAG_RST = 1'b0;
   // one instruction period is four clock phases
   typedef enum logic [3:0] {
      PH_FETCH = 4'h1,
      PH_READ = 4'h2,
      PH_EXEC = 4'h4,
      PH_WRITE = 4'h8
   } phase_t;
endpackage

// >>> rtl/core_alu_bit_skip_ops.sv
// execution datapath: add/and, bit set/clear, clear file and bit-test skip
// Operation
// - add_literal_to_acc adds literal to accumulator, updates spill, half carry, nil
// - and_acc_with_file ANDs accumulator with addressed file register, nil only
// - add_acc_to_file adds accumulator and file register, updates all three flags
// - destination bit 0 writes accumulator, 1 writes back file register
// - clear_bit_in_file zeroes indexed bit, other bits and flags untouched
// - set_bit_in_file sets indexed bit, other bits and flags untouched
// - and_literal_with_acc ANDs literal into accumulator, nil only
// - skip_if_bit_set discards next instruction as no-op when bit is one
// - skip_if_bit_clear discards next instruction as no-op when bit is zero
// - unmet skip test lets next instruction run, flags unchanged
// - clear_file writes zero to file register and sets nil
// - instruction period is four clocks; skip gives no-op second period
// - port registers use sensed pin values as operand
`timescale 1ns/1ps
`default_nettype none
module core_alu_bit_skip_ops (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // instruction from the sequencer
   input wire logic instr_valid_i,
   input wire logic [core_alu_pkg::INSTR_W-1:0] instr_i,
   // file register space
   output logic [core_alu_pkg::ADDR_W-1:0] file_addr_o,
   input wire logic [core_alu_pkg::DATA_W-1:0] file_rd_data_i,
   input wire logic file_is_port_i,
   input wire logic [core_alu_pkg::DATA_W-1:0] pin_data_i,
   output logic file_wr_o,
   output logic [core_alu_pkg::DATA_W-1:0] file_wr_data_o,
   // accumulator and flags
   output logic [core_alu_pkg::DATA_W-1:0] acc_o,
   output logic bit7_spill_o,
   output logic half_carry_flag_o,
   output logic nil_result_o,
   // sequencing
   output logic [3:0] phase_o,
   output logic nop_slot_o
);
   import core_alu_pkg::*;

   phase_t phase_q;
   phase_t phase_d;
   logic [INSTR_W-1:0] instr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] operand_q;
   logic [DATA_W-1:0] acc_q;
   logic spill_q;
   logic half_q;
   logic nil_q;
   logic wr_q;
   logic [DATA_W-1:0] wr_data_q;
   logic nop_slot_q;

   // phase divider: one instruction period every four clocks
   always_comb begin
      case (phase_q)
         PH_FETCH: phase_d = PH_READ;
         PH_READ: phase_d = PH_EXEC;
         PH_EXEC: phase_d = PH_WRITE;
         PH_WRITE: phase_d = PH_FETCH;
         default: phase_d = PH_FETCH;
      endcase
   end

   wire fetch_en = (phase_q == PH_FETCH);
   wire capture_en = (phase_q == PH_EXEC);
   wire commit_en = (phase_q == PH_WRITE);

   // a discarded slot loads the no-op word instead of the offered one
   wire take_instr = instr_valid_i && !nop_slot_q;
   wire [INSTR_W-1:0] fetch_word = take_instr ? instr_i : INSTR_NOP;

   // decode
   wire is_add_file = (instr_q[13:8] == OPC_ADD_FILE);
   wire is_and_file = (instr_q[13:8] == OPC_AND_FILE);
   wire is_clear_file = (instr_q[13:7] == OPC_CLEAR_FILE);
   wire is_bit_clear = (instr_q[13:10] == OPC_BIT_CLEAR);
   wire is_bit_set = (instr_q[13:10] == OPC_BIT_SET);
   wire is_skip_clear = (instr_q[13:10] == OPC_SKIP_CLEAR);
   wire is_skip_set = (instr_q[13:10] == OPC_SKIP_SET);
   wire is_add_lit = (instr_q[13:9] == OPC_ADD_LIT);
   wire is_and_lit = (instr_q[13:8] == OPC_AND_LIT);

   wire dest_file = instr_q[DEST_POS];
   wire [BIT_IDX_W-1:0] bit_idx = instr_q[BIT_IDX_LSB +: BIT_IDX_W];
   wire [DATA_W-1:0] literal = instr_q[LIT_LSB +: DATA_W];
   wire is_lit = is_add_lit || is_and_lit;
   wire is_add = is_add_lit || is_add_file;
   wire is_and = is_and_lit || is_and_file;
   wire is_file_alu = is_add_file || is_and_file;

   // port registers read back what the pins show, not the latch
   wire [DATA_W-1:0] sensed = file_is_port_i ? pin_data_i : file_rd_data_i;

   // arithmetic and logic
   wire [DATA_W-1:0] opnd = is_lit ? literal : operand_q;
   wire [DATA_W:0] sum9 = {1'b0, acc_q} + {1'b0, opnd};
   wire [4:0] low5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
   wire [DATA_W-1:0] and_res = acc_q & opnd;
   wire [DATA_W-1:0] bit_mask = BIT_ONE << bit_idx;
   wire [DATA_W-1:0] clr_res = operand_q & ~bit_mask;
   wire [DATA_W-1:0] set_res = operand_q | bit_mask;
   wire [DATA_W-1:0] result = is_add ? sum9[DATA_W-1:0] :
                              is_and ? and_res :
                              is_bit_clear ? clr_res :
                              is_bit_set ? set_res : DATA_ZERO;

   // destination steering
   wire wr_file = (is_file_alu && dest_file) || is_bit_clear || is_bit_set || is_clear_file;
   wire wr_acc = is_lit || (is_file_alu && !dest_file);
   // bit ops and skip tests never touch flags
   wire upd_nil = is_add || is_and || is_clear_file;
   wire upd_carry = is_add;
   wire nil_d = is_clear_file ? 1'b1 : (result == DATA_ZERO);

   // skip decision
   wire tested_bit = operand_q[bit_idx];
   wire skip_hit = (is_skip_set && tested_bit) || (is_skip_clear && !tested_bit);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         phase_q <= PH_FETCH;
         instr_q <= INSTR_NOP;
         addr_q <= ADDR_RST;
         operand_q <= DATA_ZERO;
      end else begin
         phase_q <= phase_d;
         if (fetch_en) begin
            instr_q <= fetch_word;
            addr_q <= fetch_word[ADDR_LSB +: ADDR_W];
         end
         if (capture_en) begin
            operand_q <= sensed;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         acc_q <= ACC_RST;
         spill_q <= FLAG_RST;
         half_q <= FLAG_RST;
         nil_q <= FLAG_RST;
      end else if (commit_en) begin
         if (wr_acc) begin
            acc_q <= result;
         end
         if (upd_carry) begin
            spill_q <= sum9[DATA_W];
            half_q <= low5[4];
         end
         if (upd_nil) begin
            nil_q <= nil_d;
         end
      end
   end

   // write strobe lasts one clock; the skip marks the whole next period
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_q <= 1'b0;
         wr_data_q <= DATA_ZERO;
         nop_slot_q <= 1'b0;
      end else begin
         wr_q <= commit_en && wr_file;
         if (commit_en) begin
            wr_data_q <= result;
            nop_slot_q <= skip_hit;
         end
      end
   end

   assign file_addr_o = addr_q;
   assign file_wr_o = wr_q;
   assign file_wr_data_o = wr_data_q;
   assign acc_o = acc_q;
   assign bit7_spill_o = spill_q;
   assign half_carry_flag_o = half_q;
   assign nil_result_o = nil_q;
   assign phase_o = phase_q;
   assign nop_slot_o = nop_slot_q;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // expected values rebuilt apart from the adder's own carry chain
   wire [DATA_W-1:0] chk_add_lit = DATA_W'(acc_q + literal);
   wire [DATA_W-1:0] chk_and_lit = acc_q & literal;
   wire [DATA_W-1:0] chk_add_file = DATA_W'(acc_q + operand_q);
   wire chk_c7 = (acc_q[7] && opnd[7]) || ((acc_q[7] || opnd[7]) && !sum9[7]);
   wire chk_c3 = (acc_q[3] && opnd[3]) || ((acc_q[3] || opnd[3]) && !sum9[3]);

   sequence s_commit_skip;
      commit_en && skip_hit;
   endsequence
   sequence s_discard_period;
      nop_slot_q [*4] ##1 !nop_slot_q;
   endsequence
   // the file space must see exactly one write clock per commit that writes a file register
   sequence s_one_strobe;
      wr_q ##1 !wr_q;
   endsequence

   // sequencing
   a_period_four: assert property (fetch_en |-> ##4 fetch_en)
      else $error("instruction period is not four clocks");
   a_phase_one_hot: assert property ($onehot(phase_q))
      else $error("phase is not one-hot");
   a_taken_word: assert property (fetch_en && instr_valid_i && !nop_slot_q |=>
      instr_q == $past(instr_i) && file_addr_o == $past(instr_i[ADDR_W-1:0]))
      else $error("offered word not taken at fetch");
   a_invalid_nop: assert property (fetch_en && !instr_valid_i |=> instr_q == INSTR_NOP && addr_q == ADDR_RST)
      else $error("missing word did not load a no-op");
   a_addr_hold: assert property (!fetch_en |=> $stable(addr_q) && $stable(instr_q))
      else $error("address moved outside fetch");
   a_operand_hold: assert property (!capture_en |=> $stable(operand_q))
      else $error("operand moved outside capture");
   a_flags_hold_idle: assert property (!commit_en |=>
      $stable(acc_q) && $stable(spill_q) && $stable(half_q) && $stable(nil_q) && $stable(wr_data_q) && $stable(nop_slot_q))
      else $error("state changed outside the write phase");

   // arithmetic and logic results
   a_add_lit_sum: assert property (commit_en && is_add_lit |=>
      acc_q == $past(chk_add_lit) && bit7_spill_o == $past(sum9[8]) && half_q == $past(low5[4]))
      else $error("literal add result or flags wrong");
   a_and_file_nil: assert property (commit_en && is_and_file |=>
      nil_q == ($past(and_res) == DATA_ZERO) && $stable(spill_q) && $stable(half_q))
      else $error("file and must touch only nil");
   a_add_file_flags: assert property (commit_en && is_add_file |=>
      spill_q == $past(sum9[8]) && half_q == $past(low5[4]) && nil_q == ($past(sum9[7:0]) == DATA_ZERO))
      else $error("file add flags wrong");
   a_and_lit_acc: assert property (commit_en && is_and_lit |=>
      acc_q == $past(chk_and_lit) && $stable(spill_q) && nil_q == (acc_q == DATA_ZERO))
      else $error("literal and result wrong");
   a_nil_from_result: assert property (commit_en && upd_nil && !is_clear_file |=>
      nil_q == ($past(result) == DATA_ZERO))
      else $error("nil flag does not follow the result");
   a_carry_bits: assert property (commit_en && is_add |=>
      spill_q == $past(chk_c7) && half_q == $past(chk_c3))
      else $error("carry flags do not match the operand bits");

   // destination steering and write strobe
   a_dest_to_file: assert property (commit_en && is_file_alu && dest_file |=>
      wr_q && wr_data_q == $past(result) && $stable(acc_q) ##1 !wr_q)
      else $error("file destination not written once");
   a_dest_to_acc: assert property (commit_en && is_file_alu && !dest_file |=>
      !wr_q && acc_q == $past(result))
      else $error("accumulator destination not honoured");
   a_and_file_data: assert property (commit_en && is_and_file && dest_file |=>
      wr_data_q == ($past(acc_q) & $past(operand_q)) && $stable(acc_q))
      else $error("file and written back wrong");
   a_add_file_data: assert property (commit_en && is_add_file && dest_file |=>
      wr_data_q == $past(chk_add_file) && $stable(acc_q))
      else $error("file add written back wrong");
   a_add_acc_dest: assert property (commit_en && is_add_file && !dest_file |=>
      acc_q == $past(chk_add_file) && !wr_q)
      else $error("file add into accumulator wrong");
   a_lit_no_strobe: assert property (commit_en && is_lit |=> !wr_q)
      else $error("literal operation strobed the file space");
   a_strobe_single: assert property (wr_q |-> s_one_strobe)
      else $error("write strobe longer than one clock");
   a_strobe_in_fetch: assert property (wr_q |-> phase_q == PH_FETCH)
      else $error("write strobe outside the fetch phase");

   // bit operations and clear
   a_bit_clear_only: assert property (commit_en && is_bit_clear |=>
      wr_q && wr_data_q == ($past(operand_q) & ~$past(bit_mask)) && $stable(nil_q) && $stable(spill_q))
      else $error("bit clear changed other state");
   a_bit_set_only: assert property (commit_en && is_bit_set |=>
      wr_q && wr_data_q == ($past(operand_q) | $past(bit_mask)) && $stable(half_q) && $stable(nil_q))
      else $error("bit set changed other state");
   a_bit_ops_keep: assert property (commit_en && (is_bit_clear || is_bit_set) |=>
      $stable(acc_q) && $stable(spill_q) && $stable(half_q) && $stable(nil_q) && !nop_slot_q)
      else $error("bit operation touched accumulator or flags");
   a_clear_file_nil: assert property (commit_en && is_clear_file |=>
      wr_q && wr_data_q == DATA_ZERO && nil_q)
      else $error("clear file did not zero and set nil");
   a_clear_file_keep: assert property (commit_en && is_clear_file |=>
      $stable(acc_q) && $stable(spill_q) && $stable(half_q))
      else $error("clear file touched accumulator or carries");

   // skip tests and the discarded slot
   a_skip_set_nop: assert property (s_commit_skip and (is_skip_set && tested_bit) |=> s_discard_period)
      else $error("set-bit skip did not discard one period");
   a_skip_clear_nop: assert property (commit_en && is_skip_clear && !tested_bit |=> s_discard_period)
      else $error("clear-bit skip did not discard one period");
   a_skip_not_met: assert property (commit_en && (is_skip_set || is_skip_clear) && !skip_hit |=>
      !nop_slot_q && $stable(nil_q) && $stable(spill_q) && $stable(half_q))
      else $error("unmet skip altered flow or flags");
   a_skip_no_write: assert property (commit_en && (is_skip_set || is_skip_clear) |=>
      !wr_q && $stable(acc_q))
      else $error("skip test wrote state");
   a_discard_loads_nop: assert property (fetch_en && nop_slot_q |=> instr_q == INSTR_NOP)
      else $error("discarded slot did not execute a no-op");
   a_discard_no_effect: assert property (commit_en && nop_slot_q |=>
      !wr_q && !nop_slot_q && $stable(acc_q) && $stable(nil_q) && $stable(spill_q) && $stable(half_q))
      else $error("discarded slot changed state");
   a_slot_starts_fetch: assert property ($rose(nop_slot_q) |-> phase_q == PH_FETCH)
      else $error("discarded slot does not start at fetch");

   // port operands
   a_port_operand: assert property (capture_en && file_is_port_i |=> operand_q == $past(pin_data_i))
      else $error("port operand not taken from pins");
   a_latch_operand: assert property (capture_en && !file_is_port_i |=> operand_q == $past(file_rd_data_i))
      else $error("memory operand not taken from file data");
endmodule
`default_nettype wire

// >>> tb/file_regs_model.sv
// behavioural file register space with one port register sensed through its pins
`timescale 1ns/1ps
`default_nettype none
module file_regs_model #(parameter logic [6:0] PORT_ADDR = 7'h06) (
   // clock
   input wire logic clk_i,
   // access from the datapath
   input wire logic [6:0] addr_i,
   input wire logic wr_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o,
   output logic is_port_o,
   output logic [7:0] pin_o
);
   logic [7:0] mem_q [128];
   initial for (int i = 0; i < 128; i++) mem_q[i] = 8'h00;
   always @(posedge clk_i) if (wr_i) mem_q[addr_i] <= wr_data_i;
   assign is_port_o = (addr_i == PORT_ADDR);
   assign rd_data_o = mem_q[addr_i];
   // pins read opposite to the latch, so a latch operand cannot pass unseen
   assign pin_o = ~mem_q[addr_i];
endmodule
`default_nettype wire

// >>> tb/tb_core_alu_bit_skip_ops.sv
// self-checking bench: random instruction stream against an integer model
`timescale 1ns/1ps
`default_nettype none
module tb_core_alu_bit_skip_ops;
   import core_alu_pkg::*;
   localparam logic [6:0] PORT_ADDR = 7'h06;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic instr_valid_i = 1'b0;
   logic [INSTR_W-1:0] instr_i = INSTR_NOP;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] rd_data, pin_data, wr_data, acc;
   logic is_port, wr, spill, half, nil, nop_slot;
   logic [3:0] phase;
   logic [31:0] lfsr_q = 32'hAB6592DB;
   int fail_count = 0;
   int n_compared = 0;
   int m_acc = 0, m_c = 0, m_dc = 0, m_z = 0, skip_next = 0;
   int mem [128];
   core_alu_bit_skip_ops u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .file_addr_o(addr), .file_rd_data_i(rd_data), .file_is_port_i(is_port),
      .pin_data_i(pin_data), .file_wr_o(wr), .file_wr_data_o(wr_data), .acc_o(acc),
      .bit7_spill_o(spill), .half_carry_flag_o(half), .nil_result_o(nil), .phase_o(phase),
      .nop_slot_o(nop_slot));
   file_regs_model #(.PORT_ADDR(PORT_ADDR)) u_fregs (.clk_i(ref_clk_i), .addr_i(addr), .wr_i(wr),
      .wr_data_i(wr_data), .rd_data_o(rd_data), .is_port_o(is_port), .pin_o(pin_data));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one instruction period; entered and left at a falling edge inside FETCH
   task automatic run_one(input int op, input int a, input int d, input int b, input int k, input int v);
      logic [13:0] w;
      int f, r, wr_e, wd, sk;
      case (op)
         0: w = {OPC_ADD_LIT, 1'b0, k[7:0]};
         1: w = {OPC_AND_LIT, k[7:0]};
         2: w = {OPC_ADD_FILE, d[0], a[6:0]};
         3: w = {OPC_AND_FILE, d[0], a[6:0]};
         4: w = {OPC_CLEAR_FILE, a[6:0]};
         5: w = {OPC_BIT_CLEAR, b[2:0], a[6:0]};
         6: w = {OPC_BIT_SET, b[2:0], a[6:0]};
         7: w = {OPC_SKIP_SET, b[2:0], a[6:0]};
         8: w = {OPC_SKIP_CLEAR, b[2:0], a[6:0]};
         // a word outside this datapath's set must behave as a no-op
         default: w = {2'h2, k[7:0], a[3:0]};
      endcase
      f = (a == PORT_ADDR) ? (~mem[a]) & 255 : mem[a];
      wr_e = 0;
      wd = 0;
      sk = 0;
      // a word discarded or not offered must leave everything untouched
      if (skip_next == 0 && v != 0) begin
         case (op)
            0, 2: begin
               r = m_acc + ((op == 0) ? k : f);
               m_c = r >> 8;
               m_dc = ((m_acc & 15) + (((op == 0) ? k : f) & 15)) >> 4;
               r = r & 255;
            end
            1: r = m_acc & k;
            3: r = m_acc & f;
            4: r = 0;
            5: r = f & ~(1 << b) & 255;
            6: r = f | (1 << b);
            7: sk = (f >> b) & 1;
            8: sk = ((f >> b) & 1) ^ 1;
            default: r = 0;
         endcase
         if (op <= 4) m_z = (r == 0);
         if (op <= 1 || (op <= 3 && d == 0)) m_acc = r;
         else if (op <= 6) begin
            wr_e = 1;
            wd = r;
         end
      end
      if (wr_e != 0) mem[a] = wd;
      instr_i = w;
      instr_valid_i = (v != 0);
      repeat (4) @(negedge ref_clk_i);
      chk(16'(phase), 16'(PH_FETCH));
      chk({9'h000, addr}, 16'((skip_next == 0 && v != 0) ? w[6:0] : 7'h00));
      chk({8'h00, acc}, 16'(m_acc));
      chk({13'h0000, spill, half, nil}, 16'(m_c * 4 + m_dc * 2 + m_z));
      chk({15'h0000, wr}, 16'(wr_e));
      if (wr_e != 0) chk({8'h00, wr_data}, 16'(wd));
      chk({15'h0000, nop_slot}, 16'(sk));
      skip_next = sk;
   endtask
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // 400 periods of four cycles is 100 periods beyond the 300-period run
   initial begin
      #(400 * 4 * 5);
      fail_count++;
      give_verdict();
   end
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 0;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk(16'(phase), 16'(PH_FETCH));
      chk({8'h00, acc}, 16'h0000);
      for (int i = 0; i < 300; i++) begin
         // second reset mid-stream, raised and released inside a fetch phase
         if (i == 150) begin
            rst_i = 1'b1;
            repeat (2) @(negedge ref_clk_i);
            rst_i = 1'b0;
            m_acc = 0;
            m_c = 0;
            m_dc = 0;
            m_z = 0;
            skip_next = 0;
            chk(16'(phase), 16'(PH_FETCH));
            chk({5'h00, acc, spill, half, nil}, 16'h0000);
            chk({14'h0000, wr, nop_slot}, 16'h0000);
         end
         lfsr_q = lfsr_next(lfsr_q);
         run_one(int'(lfsr_q[7:0]) % 10, (lfsr_q[15:14] == 2'h0) ? int'(PORT_ADDR) : int'(lfsr_q[22:16]),
            int'(lfsr_q[9]), int'(lfsr_q[12:10]), int'(lfsr_q[31:24]), int'(lfsr_q[23:21] != 3'h0));
      end
      give_verdict();
   end
endmodule
`default_nettype wire
